/* hw/fsp_pkg.sv */
package fsp_pkg;

  // Pin widths
  localparam int unsigned ADDR_W   = 20;
  localparam int unsigned HALF_W   = 16;
  localparam int unsigned RC_W     = 12;
  localparam int unsigned BANK_LSB = 15;
  localparam int unsigned BE_LSB   = 18;

  // Boot values and minimums of the timing set
  localparam logic [6:0] ACC_LEN_RST = 7'h14;
  localparam logic [6:0] ACC_LEN_MIN = 7'h02;
  localparam logic [3:0] REL_LEN_RST = 4'h4;
  localparam logic [4:0] DD_RST      = 5'h0a;
  localparam logic [3:0] EDGE_RST    = 4'h0;
  localparam logic [2:0] UNITS_RST   = 3'h0;
  localparam logic [2:0] CAS_LAT_RST = 3'h2;
  localparam logic [2:0] CAS_LAT_MIN = 3'h1;
  // Boot: select and output enable on reads only, write strobe never
  localparam logic [5:0] CTL_EN_RST  = 6'h03;

  // Per-operation strobe enable bit positions
  localparam int unsigned CE_RD_CS = 0;
  localparam int unsigned CE_RD_OE = 1;
  localparam int unsigned CE_RD_WE = 2;
  localparam int unsigned CE_WR_CS = 3;
  localparam int unsigned CE_WR_OE = 4;
  localparam int unsigned CE_WR_WE = 5;

  // Window slots; unit bits use the first three
  localparam int unsigned WIN_CS = 0;
  localparam int unsigned WIN_OE = 1;
  localparam int unsigned WIN_WE = 2;
  localparam int unsigned WIN_DD = 3;
  localparam int unsigned WIN_N  = 4;

  // Command encodings {row strobe, column strobe, rd_wr}, all low active
  localparam logic [2:0] CMD_NOP  = 3'h7;
  localparam logic [2:0] CMD_READ = 3'h5;

  // Last cycle index of a dynamic RAM command, which is held two cycles (one divided clock period)
  localparam logic [6:0] SD_CMD_LAST = 7'h01;

  typedef enum logic [2:0] {
    FSP_IDLE,
    FSP_FLASH,
    FSP_RELEASE,
    FSP_SD_CMD,
    FSP_SD_WAIT
  } fsp_state_t;

  typedef struct packed {
    logic       wide;
    logic       wr_en;
    logic [5:0] ctl_en;
    logic [6:0] acc_len;
    logic [3:0] rel_len;
    logic [4:0] dd;
    logic [3:0] csr_fall;
    logic [3:0] csr_rise;
    logic [3:0] csw_fall;
    logic [3:0] csw_rise;
    logic [3:0] oe_fall;
    logic [3:0] oe_rise;
    logic [3:0] we_fall;
    logic [3:0] we_rise;
    logic [2:0] units;
    logic [2:0] cas_lat;
    logic       clk_inv;
  } fsp_cfg_t;

endpackage

/* hw/fsp_edge_win.sv */
`timescale 1ns/1ps
// Strobe window in half-cycle steps for one access cycle
module fsp_edge_win (
  input  wire logic [6:0] pos_i,   // Cycle index within access
  input  wire logic [6:0] len_i,   // Access length in cycles
  input  wire logic [4:0] fall_i,  // Offset after start
  input  wire logic [4:0] rise_i,  // Offset before end
  input  wire logic       unit_i,  // 1: phases, 0: cycles
  input  wire logic       en_i,    // Strobe used this access
  output logic      [1:0] act_o    // Active in first/second half
);

  // Offsets and positions all counted in phases
  always_comb begin
    logic [7:0] start_ph;
    logic [7:0] rise_ph;
    logic [7:0] tot_ph;
    logic [7:0] pos_ph;
    start_ph = '0;
    rise_ph  = '0;
    tot_ph   = '0;
    pos_ph   = '0;
    act_o    = '0;
    // Cycle units double the offsets
    start_ph = unit_i ? {3'h0, fall_i} : {2'h0, fall_i, 1'b0};
    rise_ph  = unit_i ? {3'h0, rise_i} : {2'h0, rise_i, 1'b0};
    tot_ph   = {len_i, 1'b0};
    pos_ph   = {pos_i, 1'b0};
    for (int h = 0; h < 2; h++) begin
      // Oversized offsets give an empty window instead of wrapping
      act_o[h] = en_i && (tot_ph > rise_ph) &&
                 ((pos_ph | 8'(h)) >= start_ph) &&
                 ((pos_ph | 8'(h)) < (tot_ph - rise_ph));
    end
  end

endmodule

/* hw/fsp_port.sv */
`timescale 1ns/1ps
// Contract
// - Flash and dynamic RAM accesses never overlap
// - Flash on low data half, RAM high
// - Flash gets full unmultiplexed 20-bit address
// - RAM banks on lines 15,16; row/col 0-11
// - Wide RAM: low byte enables on 18,19
// - Wide RAM: byte-enable pins carry lanes 3,2
// - Separate low-active selects for both memories
// - Read/write pin serves Flash when writes enabled
// - Column strobe doubles as Flash output enable
// - RAM clock out, feedback captures read data
// - Pin roles set by software, not straps
// - Flash read asynchronously, no clock, no bursts
// - Arbitrary address and data on writes
// - Per-operation choice of select, write, output enable
// - Access length 2 to 127 cycles
// - Bus release 0 to 15 cycles after Flash
// - Write data starts 0-31 phases after start
// - Read select edges offset 0-15 units
// - Write select edges offset separately, 0-15
// - Read output enable edges offset 0-15
// - Write strobe edges offset 0-15 units
// - Boot access length is 20 cycles
// - Boot allows reads only, write strobe idle
module fsp_port #(
  parameter int unsigned ADDR_W = fsp_pkg::ADDR_W,  // Address pins
  parameter int unsigned HALF_W = fsp_pkg::HALF_W   // Data pins per half
) (
  input  wire logic        core_clk_i, // System clock
  input  wire logic        rst_b_i, // Sync reset, low
  input  wire logic        cfg_load_i, // Take cfg_* ports
  input  wire logic        cfg_wide_i, // 32-bit RAM fitted
  input  wire logic        cfg_flash_wr_en_i, // Flash writes allowed
  input  wire logic [5:0]  cfg_ctl_en_i, // Strobe use per op
  input  wire logic [6:0]  cfg_access_len_i, // Access cycles
  input  wire logic [3:0]  cfg_release_len_i, // Release cycles
  input  wire logic [4:0]  cfg_data_delay_i, // Data drive phases
  input  wire logic [3:0]  cfg_sel_fall_read_i, // Read select fall
  input  wire logic [3:0]  cfg_sel_rise_read_i, // Read select rise
  input  wire logic [3:0]  cfg_sel_fall_write_i, // Write select fall
  input  wire logic [3:0]  cfg_sel_rise_write_i, // Write select rise
  input  wire logic [3:0]  cfg_oe_fall_read_i, // Output enable fall
  input  wire logic [3:0]  cfg_oe_rise_read_i, // Output enable rise
  input  wire logic [3:0]  cfg_wr_fall_i, // Write strobe fall
  input  wire logic [3:0]  cfg_wr_rise_i, // Write strobe rise
  input  wire logic [2:0]  cfg_phase_units_i, // Phase units cs/oe/we
  input  wire logic [2:0]  cfg_cas_lat_i, // RAM read latency
  input  wire logic        cfg_clk_invert_i, // RAM clock polarity
  output logic             cfg_wide_o, // Loaded width
  output logic             cfg_flash_wr_en_o, // Loaded write enable
  input  wire logic        req_valid_i, // Request offered
  output logic             req_ready_o, // Request taken
  input  wire logic        req_flash_i, // 1 Flash, 0 RAM
  input  wire logic        req_write_i, // Flash write
  input  wire logic [19:0] req_addr_i, // Flash address
  input  wire logic [1:0]  req_bank_i, // RAM bank
  input  wire logic [11:0] req_row_col_i, // RAM row or column
  input  wire logic [2:0]  req_cmd_i, // RAM command bits
  input  wire logic [31:0] req_wdata_i, // Write data
  input  wire logic [3:0]  req_be_n_i, // Byte enables, low
  output logic             rsp_valid_o, // Access done pulse
  output logic             rsp_err_o, // Refused write
  output logic [31:0]      rsp_data_o, // Read data
  output logic             busy_o, // Not idle
  output logic [19:0]      addr_o, // Shared address
  input  wire logic [15:0] flash_d_i, // Flash data in
  output logic [15:0]      flash_d_o, // Flash data out
  output logic [1:0]       flash_d_oe_n_o, // Drive, per half
  input  wire logic [15:0] sdram_d_i, // RAM data in
  output logic [15:0]      sdram_d_o, // RAM data out
  output logic             sdram_d_oe_n_o, // Drive, low
  output logic [1:0]       flash_cs_n_o, // Flash select halves
  output logic             sdram_cs_n_o, // RAM select
  output logic             ras_n_o, // Row strobe
  output logic [1:0]       cas_n_o, // Column strobe / OE
  output logic [1:0]       rd_wr_n_o, // Read/write strobe
  output logic [1:0]       byte_lane_en_n_o, // Byte enables pins
  output logic             dyn_ram_clk_out_o, // RAM clock
  input  wire logic        dyn_ram_clk_feedback_i // RAM clock back
);

  // Pin widths are fixed by the board wiring
  if (ADDR_W != 20 || HALF_W != 16) begin : g_chk
    $error("fsp_port supports only 20 address and 16 data pins");
  end

  typedef struct packed {
    fsp_pkg::fsp_state_t st;       // Sequencer state
    fsp_pkg::fsp_cfg_t   cfg;      // Software timing set
    logic [6:0]          cyc;      // Cycle within access
    logic [3:0]          rel;      // Release cycles left
    logic [2:0]          lat;      // Feedback edges left
    logic                op_wr;    // Flash write in progress
    logic                op_rd;    // RAM read in progress
    logic                clk_div;  // Divided RAM clock
    logic [1:0]          fb_s;     // Feedback synchroniser
    logic                fb_q;     // Feedback previous
    logic [15:0]         fd_s1;    // Flash data stage 1
    logic [15:0]         fd_s2;    // Flash data stage 2
    logic [15:0]         sd_s1;    // RAM data stage 1
    logic [15:0]         sd_s2;    // RAM data stage 2
    logic [19:0]         addr;     // Address pins
    logic [15:0]         fd_out;   // Flash data pins
    logic [1:0]          fd_oe_n;  // Flash data drive
    logic [15:0]         sd_out;   // RAM data pins
    logic                sd_oe_n;  // RAM data drive
    logic [1:0]          fcs_n;    // Flash select
    logic                scs_n;    // RAM select
    logic                ras_n;    // Row strobe
    logic [1:0]          cas_n;    // Column strobe
    logic [1:0]          rdwr_n;   // Read/write strobe
    logic [1:0]          be_n;     // Byte enable pins
    logic                rsp_v;    // Response pulse
    logic                rsp_e;    // Response error
    logic [31:0]         rsp_d;    // Response data
  } fsp_port_st_t;

  fsp_port_st_t r;        // Registered state
  fsp_port_st_t n;        // Next state

  logic       flash_go; // Flash access starts
  logic       flash_bad; // Flash write refused
  logic       sd_go; // RAM command starts
  logic       last_cyc; // Final access cycle
  logic       nx_in; // Next cycle in access
  logic [6:0] nx_pos; // Next cycle index
  logic       nx_wr; // Next access is a write
  logic [4:0] w_fall [fsp_pkg::WIN_N]; // Window fall offsets
  logic [4:0] w_rise [fsp_pkg::WIN_N]; // Window rise offsets
  logic       w_unit [fsp_pkg::WIN_N]; // Window unit selects
  logic       w_en   [fsp_pkg::WIN_N]; // Window enables
  logic [1:0] w_act  [fsp_pkg::WIN_N]; // Window outputs

  // Pick one bit of the per-operation enable set
  function automatic logic ctl_bit(input logic [5:0] en, input logic wr,
                                   input int unsigned rd_pos,
                                   input int unsigned wr_pos);
    ctl_bit = wr ? en[wr_pos] : en[rd_pos];
  endfunction

  // Start decisions; one sequencer serialises both memories
  assign flash_bad = req_write_i && !r.cfg.wr_en;
  assign flash_go  = (r.st == fsp_pkg::FSP_IDLE) && req_valid_i && req_flash_i
                     && !flash_bad;
  // RAM commands align to the low phase of the divided clock
  assign sd_go     = (r.st == fsp_pkg::FSP_IDLE) && req_valid_i && !req_flash_i
                     && !r.clk_div;
  assign req_ready_o = (r.st == fsp_pkg::FSP_IDLE) &&
                       (req_flash_i || !r.clk_div);
  assign last_cyc  = r.cyc == (r.cfg.acc_len - 7'h01);
  assign nx_in     = flash_go || (r.st == fsp_pkg::FSP_FLASH && !last_cyc);
  assign nx_pos    = (r.st == fsp_pkg::FSP_FLASH) ? r.cyc + 7'h01 : 7'h00;
  assign nx_wr     = flash_go ? req_write_i : r.op_wr;

  // Window parameters for the coming cycle
  always_comb begin
    w_fall[fsp_pkg::WIN_CS] = nx_wr ? {1'b0, r.cfg.csw_fall}
                                    : {1'b0, r.cfg.csr_fall};
    w_rise[fsp_pkg::WIN_CS] = nx_wr ? {1'b0, r.cfg.csw_rise}
                                    : {1'b0, r.cfg.csr_rise};
    w_fall[fsp_pkg::WIN_OE] = {1'b0, r.cfg.oe_fall};
    w_rise[fsp_pkg::WIN_OE] = {1'b0, r.cfg.oe_rise};
    w_fall[fsp_pkg::WIN_WE] = {1'b0, r.cfg.we_fall};
    w_rise[fsp_pkg::WIN_WE] = {1'b0, r.cfg.we_rise};
    w_fall[fsp_pkg::WIN_DD] = r.cfg.dd;
    w_rise[fsp_pkg::WIN_DD] = 5'h00;
    w_unit[fsp_pkg::WIN_CS] = r.cfg.units[fsp_pkg::WIN_CS];
    w_unit[fsp_pkg::WIN_OE] = r.cfg.units[fsp_pkg::WIN_OE];
    w_unit[fsp_pkg::WIN_WE] = r.cfg.units[fsp_pkg::WIN_WE];
    w_unit[fsp_pkg::WIN_DD] = 1'b1;
    // Software picks which strobes each operation uses
    w_en[fsp_pkg::WIN_CS] = nx_in && ctl_bit(r.cfg.ctl_en, nx_wr,
                            fsp_pkg::CE_RD_CS, fsp_pkg::CE_WR_CS);
    w_en[fsp_pkg::WIN_OE] = nx_in && ctl_bit(r.cfg.ctl_en, nx_wr,
                            fsp_pkg::CE_RD_OE, fsp_pkg::CE_WR_OE);
    // Write strobe reaches the Flash only once writes are enabled
    w_en[fsp_pkg::WIN_WE] = nx_in && r.cfg.wr_en &&
                            ctl_bit(r.cfg.ctl_en, nx_wr,
                            fsp_pkg::CE_RD_WE, fsp_pkg::CE_WR_WE);
    w_en[fsp_pkg::WIN_DD] = nx_in && nx_wr;
  end

  // One window per strobe plus the data drive
  for (genvar i = 0; i < fsp_pkg::WIN_N; i++) begin : g_win
    fsp_edge_win u_win (
      .pos_i  (nx_pos),
      .len_i  (r.cfg.acc_len),
      .fall_i (w_fall[i]),
      .rise_i (w_rise[i]),
      .unit_i (w_unit[i]),
      .en_i   (w_en[i]),
      .act_o  (w_act[i])
    );
  end

  // Sequencer and pin drive
  always_comb begin
    n = r;
    n.rsp_v = 1'b0;
    n.rsp_e = 1'b0;
    // Pin samples pass two flops before use
    n.fb_s  = {r.fb_s[0], dyn_ram_clk_feedback_i};
    n.fb_q  = r.fb_s[1];
    n.fd_s1 = flash_d_i;
    n.fd_s2 = r.fd_s1;
    n.sd_s1 = sdram_d_i;
    n.sd_s2 = r.sd_s1;
    // Free-running divided clock for the RAM
    n.clk_div = ~r.clk_div;
    // Timing set is taken only between accesses
    if (cfg_load_i && r.st == fsp_pkg::FSP_IDLE) begin
      n.cfg.wide     = cfg_wide_i;
      n.cfg.wr_en    = cfg_flash_wr_en_i;
      n.cfg.ctl_en   = cfg_ctl_en_i;
      // Lengths below the minimum are raised to it
      n.cfg.acc_len  = (cfg_access_len_i < fsp_pkg::ACC_LEN_MIN)
                       ? fsp_pkg::ACC_LEN_MIN : cfg_access_len_i;
      n.cfg.rel_len  = cfg_release_len_i;
      n.cfg.dd       = cfg_data_delay_i;
      n.cfg.csr_fall = cfg_sel_fall_read_i;
      n.cfg.csr_rise = cfg_sel_rise_read_i;
      n.cfg.csw_fall = cfg_sel_fall_write_i;
      n.cfg.csw_rise = cfg_sel_rise_write_i;
      n.cfg.oe_fall  = cfg_oe_fall_read_i;
      n.cfg.oe_rise  = cfg_oe_rise_read_i;
      n.cfg.we_fall  = cfg_wr_fall_i;
      n.cfg.we_rise  = cfg_wr_rise_i;
      n.cfg.units    = cfg_phase_units_i;
      n.cfg.cas_lat  = (cfg_cas_lat_i == 3'h0) ? fsp_pkg::CAS_LAT_MIN
                                               : cfg_cas_lat_i;
      n.cfg.clk_inv  = cfg_clk_invert_i;
    end
    // Flash strobes and data drive from the windows
    n.fcs_n   = ~w_act[fsp_pkg::WIN_CS];
    n.fd_oe_n = ~w_act[fsp_pkg::WIN_DD];
    case (r.st)
      fsp_pkg::FSP_IDLE: begin
        n.cyc = 7'h00;
        // Idle: RAM pins at no-operation, Flash data floating
        n.cas_n   = 2'b11;
        n.rdwr_n  = 2'b11;
        n.sd_oe_n = 1'b1;
        if (flash_go) begin
          n.st     = fsp_pkg::FSP_FLASH;
          n.op_wr  = req_write_i;
          n.addr   = req_addr_i;
          n.fd_out = req_wdata_i[15:0];
          n.cas_n  = ~w_act[fsp_pkg::WIN_OE];
          n.rdwr_n = ~w_act[fsp_pkg::WIN_WE];
        end else if (req_valid_i && req_flash_i && flash_bad) begin
          // Writes refused until enabled; nothing moves on the pins
          n.rsp_v = 1'b1;
          n.rsp_e = 1'b1;
        end else if (sd_go) begin
          n.st    = fsp_pkg::FSP_SD_CMD;
          n.op_rd = req_cmd_i == fsp_pkg::CMD_READ;
          n.addr  = '0;
          n.addr[fsp_pkg::BANK_LSB +: 2] = req_bank_i;
          n.addr[fsp_pkg::RC_W-1:0]      = req_row_col_i;
          if (r.cfg.wide) begin
            n.addr[fsp_pkg::BE_LSB +: 2] = req_be_n_i[1:0];
            n.be_n   = req_be_n_i[3:2];
            n.fd_out = req_wdata_i[15:0];
            n.sd_out = req_wdata_i[31:16];
          end else begin
            n.be_n   = req_be_n_i[1:0];
            n.sd_out = req_wdata_i[15:0];
          end
          n.scs_n  = 1'b0;
          n.ras_n  = req_cmd_i[2];
          n.cas_n  = {2{req_cmd_i[1]}};
          n.rdwr_n = {2{req_cmd_i[0]}};
          // Data lanes driven only for write commands
          n.sd_oe_n = req_cmd_i[0];
          n.fd_oe_n = {2{req_cmd_i[0] | ~r.cfg.wide}};
        end
      end
      fsp_pkg::FSP_FLASH: begin
        n.cas_n  = ~w_act[fsp_pkg::WIN_OE];
        n.rdwr_n = ~w_act[fsp_pkg::WIN_WE];
        if (last_cyc) begin
          // Read data latched at the end of the cycle
          n.rsp_v = 1'b1;
          if (!r.op_wr) begin
            n.rsp_d = {16'h0000, r.fd_s2};
          end
          n.rel = r.cfg.rel_len;
          n.st  = (r.cfg.rel_len == 4'h0) ? fsp_pkg::FSP_IDLE
                                          : fsp_pkg::FSP_RELEASE;
        end else begin
          n.cyc = r.cyc + 7'h01;
        end
      end
      fsp_pkg::FSP_RELEASE: begin
        // Shared bus left floating; no access may start
        n.fd_oe_n = 2'b11;
        n.sd_oe_n = 1'b1;
        n.rel     = r.rel - 4'h1;
        if (r.rel == 4'h1) begin
          n.st = fsp_pkg::FSP_IDLE;
        end
      end
      fsp_pkg::FSP_SD_CMD: begin
        n.fd_oe_n = r.fd_oe_n;
        if (r.cyc == fsp_pkg::SD_CMD_LAST) begin
          // Command held one divided period, then no-operation
          {n.ras_n, n.cas_n[0], n.rdwr_n[0]} = fsp_pkg::CMD_NOP;
          n.cas_n[1]  = 1'b1;
          n.rdwr_n[1] = 1'b1;
          n.scs_n   = 1'b1;
          n.sd_oe_n = 1'b1;
          n.fd_oe_n = 2'b11;
          n.lat     = r.cfg.cas_lat;
          n.cyc     = 7'h00;
          if (r.op_rd) begin
            n.st = fsp_pkg::FSP_SD_WAIT;
          end else begin
            n.rsp_v = 1'b1;
            n.st    = fsp_pkg::FSP_IDLE;
          end
        end else begin
          n.cyc = r.cyc + 7'h01;
        end
      end
      fsp_pkg::FSP_SD_WAIT: begin
        // Count returned clock edges, then capture the lanes
        if (r.fb_s[1] && !r.fb_q) begin
          n.lat = r.lat - 3'h1;
          if (r.lat == 3'h1) begin
            n.rsp_v = 1'b1;
            n.rsp_d = r.cfg.wide ? {r.sd_s2, r.fd_s2}
                                 : {16'h0000, r.sd_s2};
            n.st    = fsp_pkg::FSP_IDLE;
          end
        end
      end
      default: begin
        n.st = fsp_pkg::FSP_IDLE;
      end
    endcase
  end

  // State register with boot defaults
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      r              <= '0;
      r.st           <= fsp_pkg::FSP_IDLE;
      r.cfg.ctl_en   <= fsp_pkg::CTL_EN_RST;
      r.cfg.acc_len  <= fsp_pkg::ACC_LEN_RST;
      r.cfg.rel_len  <= fsp_pkg::REL_LEN_RST;
      r.cfg.dd       <= fsp_pkg::DD_RST;
      r.cfg.csr_fall <= fsp_pkg::EDGE_RST;
      r.cfg.csr_rise <= fsp_pkg::EDGE_RST;
      r.cfg.csw_fall <= fsp_pkg::EDGE_RST;
      r.cfg.csw_rise <= fsp_pkg::EDGE_RST;
      r.cfg.oe_fall  <= fsp_pkg::EDGE_RST;
      r.cfg.oe_rise  <= fsp_pkg::EDGE_RST;
      r.cfg.we_fall  <= fsp_pkg::EDGE_RST;
      r.cfg.we_rise  <= fsp_pkg::EDGE_RST;
      r.cfg.units    <= fsp_pkg::UNITS_RST;
      r.cfg.cas_lat  <= fsp_pkg::CAS_LAT_RST;
      r.fd_oe_n      <= 2'b11;
      r.sd_oe_n      <= 1'b1;
      r.fcs_n        <= 2'b11;
      r.scs_n        <= 1'b1;
      r.ras_n        <= 1'b1;
      r.cas_n        <= 2'b11;
      r.rdwr_n       <= 2'b11;
      r.be_n         <= 2'b11;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign cfg_wide_o        = r.cfg.wide;
  assign cfg_flash_wr_en_o = r.cfg.wr_en;
  assign busy_o            = r.st != fsp_pkg::FSP_IDLE;
  assign rsp_valid_o       = r.rsp_v;
  assign rsp_err_o         = r.rsp_e;
  assign rsp_data_o        = r.rsp_d;
  assign addr_o            = r.addr;
  assign flash_d_o         = r.fd_out;
  assign flash_d_oe_n_o    = r.fd_oe_n;
  assign sdram_d_o         = r.sd_out;
  assign sdram_d_oe_n_o    = r.sd_oe_n;
  assign flash_cs_n_o      = r.fcs_n;
  assign sdram_cs_n_o      = r.scs_n;
  assign ras_n_o           = r.ras_n;
  assign cas_n_o           = r.cas_n;
  assign rd_wr_n_o         = r.rdwr_n;
  assign byte_lane_en_n_o  = r.be_n;
  // Polarity flip is a flop output xor, no clock gating
  assign dyn_ram_clk_out_o = r.clk_div ^ r.cfg.clk_inv;

endmodule

/* test/fsp_port_sva.sv */
`timescale 1ns/1ps
// Port-level checks
module fsp_port_sva (
  input wire logic       core_clk_i, // Clock
  input wire logic       rst_b_i, // Reset, low
  input wire logic       cfg_load_i, // Config load
  input wire logic [6:0] cfg_access_len_i, // Access cycles
  input wire logic       busy_o, // Not idle
  input wire logic       req_valid_i, // Request offered
  input wire logic       req_ready_o, // Request taken
  input wire logic       req_flash_i, // Flash target
  input wire logic       req_write_i, // Write
  input wire logic       rsp_valid_o, // Done pulse
  input wire logic       rsp_err_o, // Refused
  input wire logic       cfg_flash_wr_en_o, // Writes allowed
  input wire logic [1:0] flash_cs_n_o, // Flash select
  input wire logic       sdram_cs_n_o, // RAM select
  input wire logic [1:0] rd_wr_n_o, // Write strobe
  input wire logic [1:0] flash_d_oe_n_o // Data drive
);
  wire take = req_valid_i && req_ready_o;  // Accepted request
  logic [6:0] len_r;                       // Stored access length
  logic [7:0] cnt_r;                       // Cycles since take
  logic       fl_r;                        // Last take was Flash
  // Length shadow, short raised to minimum
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      len_r <= fsp_pkg::ACC_LEN_RST;
      cnt_r <= 8'h00;
      fl_r  <= 1'b0;
    end else begin
      if (cfg_load_i && !busy_o) begin
        len_r <= (cfg_access_len_i < 7'h02) ? 7'h02 : cfg_access_len_i;
      end
      cnt_r <= take ? 8'h01 : cnt_r + 8'h01;
      fl_r  <= take ? req_flash_i : fl_r;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_NO_OVERLAP: assert property (flash_cs_n_o != 2'h3 |-> sdram_cs_n_o)
    else $error("both selects low");
  AST_CS_BUSY: assert property (flash_cs_n_o != 2'h3 |-> busy_o)
    else $error("select while idle");
  AST_WR_IDLE: assert property (!cfg_flash_wr_en_o && sdram_cs_n_o |-> rd_wr_n_o == 2'h3)
    else $error("write strobe while barred");
  AST_REFUSED: assert property (take && req_flash_i && req_write_i && !cfg_flash_wr_en_o
    |-> ##1 rsp_valid_o && rsp_err_o)
    else $error("write not refused");
  AST_ACC_LEN: assert property (rsp_valid_o && fl_r && !rsp_err_o |-> cnt_r == {1'b0, len_r} + 8'h01)
    else $error("access length wrong");
  AST_RELEASE: assert property (rsp_valid_o && fl_r && !rsp_err_o
    |-> !req_ready_o && flash_d_oe_n_o == 2'h3)
    else $error("no bus release");
  AST_READY_IDLE: assert property (req_ready_o |-> !busy_o)
    else $error("ready while busy");
  AST_RSP_PULSE: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("long done pulse");
  cover property (take && req_flash_i);
  cover property (rsp_valid_o && rsp_err_o);
  cover property (!sdram_cs_n_o);
endmodule
bind fsp_port fsp_port_sva chk (.*);

/* test/fsp_mem_model.sv */
`timescale 1ns/1ps
// Flash and RAM stand-in on the shared pins
module fsp_mem_model (
  input  wire logic [19:0] addr_i,  // Address pins
  input  wire logic        cs_n_i,  // Flash select
  input  wire logic        oe_n_i,  // Flash output enable
  input  wire logic        ck_i,    // RAM clock out
  output logic      [15:0] fd_o,    // Flash data pins
  output logic      [15:0] sd_o,    // RAM data pins
  output logic             fb_o     // Clock loop back
);
  logic [15:0] word_r = 16'h0000;  // Last word put out
  // Flash answers with no clock, only while selected and enabled
  always @* if (!cs_n_i && !oe_n_i) word_r = addr_i[15:0] ^ 16'ha5a5;
  // Released lines inverted: no stale data
  assign fd_o = (!cs_n_i && !oe_n_i) ? word_r : ~word_r;
  assign sd_o = {16{ck_i}};  // Undriven RAM lines toggle
  assign fb_o = ck_i;        // Clock loop closed outside
endmodule

/* test/shared_flash_sdram_pin_port_bench.sv */
`timescale 1ns/1ps
// Request side driven, memory model on pins
module shared_flash_sdram_pin_port_bench;
  logic core_clk_i = 0, rst_b_i = 0, cfg_load_i = 0, cfg_wide_i = 0, cfg_flash_wr_en_i = 0;
  logic [5:0] cfg_ctl_en_i = 6'h03;
  logic [6:0] cfg_access_len_i = 7'h14;
  logic [4:0] cfg_data_delay_i = 5'h0a;
  logic [3:0] cfg_release_len_i = 4'h4, cfg_sel_fall_read_i = 0, cfg_sel_rise_read_i = 0;
  logic [3:0] cfg_sel_fall_write_i = 0, cfg_sel_rise_write_i = 0, cfg_oe_fall_read_i = 0;
  logic [3:0] cfg_oe_rise_read_i = 0, cfg_wr_fall_i = 0, cfg_wr_rise_i = 0, req_be_n_i = 0;
  logic [2:0] cfg_phase_units_i = 0, cfg_cas_lat_i = 3'h2, req_cmd_i = 3'h7;
  logic cfg_clk_invert_i = 0, req_valid_i = 0, req_flash_i = 0, req_write_i = 0;
  logic [19:0] req_addr_i = 0, addr_o;
  logic [1:0]  req_bank_i = 0, flash_d_oe_n_o, flash_cs_n_o, cas_n_o, rd_wr_n_o, byte_lane_en_n_o;
  logic [11:0] req_row_col_i = 0;
  logic [31:0] req_wdata_i = 0, rsp_data_o;
  logic [15:0] flash_d_i, flash_d_o, sdram_d_i, sdram_d_o;
  logic cfg_wide_o, cfg_flash_wr_en_o, req_ready_o, rsp_valid_o, rsp_err_o, busy_o;
  logic sdram_d_oe_n_o, sdram_cs_n_o, ras_n_o, dyn_ram_clk_out_o, dyn_ram_clk_feedback_i;
  int fail_count = 0, comparisons = 0, cyc = 0, n;  // Tallies, cycles, latency
  fsp_port dut (.*);
  fsp_mem_model mem (.addr_i(addr_o), .cs_n_i(flash_cs_n_o[0]), .oe_n_i(cas_n_o[0]),
    .ck_i(dyn_ram_clk_out_o), .fd_o(flash_d_i), .sd_o(sdram_d_i), .fb_o(dyn_ram_clk_feedback_i));
  always #12.5 core_clk_i = ~core_clk_i;  // 40 MHz
  // Verdict and end of run, shared with the hang guard
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // One request; n ends as negedges from take to done pulse
  task automatic op(input logic fl, input logic wr, input logic [2:0] cmd, input logic [19:0] a);
    @(posedge core_clk_i);
    {req_valid_i, req_flash_i, req_write_i, req_cmd_i, req_addr_i} <= {1'b1, fl, wr, cmd, a};
    {req_bank_i, req_row_col_i, req_be_n_i, req_wdata_i} <= {a[16:15], a[11:0], a[3:0], ~a, a[11:0]};
    @(negedge core_clk_i);
    while (req_ready_o !== 1'b1) @(negedge core_clk_i);
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    @(negedge core_clk_i);
    for (n = 1; rsp_valid_o !== 1'b1; n++) @(negedge core_clk_i);
  endtask
  // Timing set load when idle; e sets all offsets
  task automatic cfg(input logic [6:0] len, input logic [3:0] rel, input logic wr, input logic e);
    while (busy_o !== 1'b0) @(negedge core_clk_i);
    @(posedge core_clk_i);
    {cfg_load_i, cfg_access_len_i, cfg_release_len_i, cfg_flash_wr_en_i, cfg_wide_i} <= {1'b1, len, rel, wr, e};
    {cfg_sel_fall_read_i, cfg_sel_rise_read_i, cfg_sel_fall_write_i, cfg_sel_rise_write_i,
     cfg_oe_fall_read_i, cfg_oe_rise_read_i, cfg_wr_fall_i, cfg_wr_rise_i} <= {8{{3'h0, e}}};
    {cfg_phase_units_i, cfg_data_delay_i, cfg_ctl_en_i, cfg_clk_invert_i} <= {{8{e}}, 6'h3b, e};
    @(posedge core_clk_i);
    cfg_load_i <= 1'b0;
    @(negedge core_clk_i);
    chk(32'(cfg_wide_o), 32'(e));
  endtask
  // Hang guard, well above the longest sequence
  always @(posedge core_clk_i) if (++cyc == 3000) begin
    fail_count++;
    close_out;
  end
  // Scenarios
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    op(1, 0, 3'h7, 20'h0_1234); chk(32'(n), 21);
    chk(32'(rsp_data_o[15:0]), 32'h0000_b791);
    op(1, 1, 3'h7, 20'h0_0042); chk({rsp_err_o, 31'(n)}, 32'h8000_0001);
    cfg(7'h02, 4'h2, 1, 0); op(1, 1, 3'h7, 20'hf_0055); chk({rsp_err_o, 31'(n)}, 3);
    op(1, 0, 3'h7, 20'h0_0001); chk(32'(n), 3);
    cfg(7'h7f, 4'hf, 1, 1); op(1, 0, 3'h7, 20'h0_5aa5); chk(32'(n), 128);
    chk(32'(rsp_data_o[15:0]), 32'h0000_ff00);
    op(0, 0, 3'h4, 20'h1_8123); chk({rsp_err_o, 31'(n)}, 3);
    op(0, 0, 3'h5, 20'h0_8077); chk(32'(rsp_err_o), 0);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    op(1, 0, 3'h7, 20'h0_0300); chk(32'(n), 21);
    close_out;
  end
endmodule
